// ==== hdl/dcfg_pkg.sv ====
// Constants and types of the sensor register bank.
// Assumes a 16-bit register map reached through 32-bit serial frames.
package dcfg_pkg;
  localparam int WORD_W    = 16;
  localparam int REG_COUNT = 21;
  localparam int RO_COUNT  = 10;
  localparam logic [6:0] LAST_OFS = 7'h14;
  localparam logic [6:0]
    DEVICE_OPERATION_CONTROL_OFS = 7'h00, SENSOR_CHANNEL_SETUP_OFS = 7'h01,
    SYSTEM_SETUP_OFS = 7'h02, ALERT_PIN_SETUP_OFS = 7'h03, X_LIMIT_SETUP_OFS = 7'h04,
    Y_LIMIT_SETUP_OFS = 7'h05, Z_LIMIT_SETUP_OFS = 7'h06, TEMP_LIMIT_SETUP_OFS = 7'h07,
    CONVERSION_FLAGS_OFS = 7'h08, X_FIELD_VALUE_OFS = 7'h09, Y_FIELD_VALUE_OFS = 7'h0A,
    Z_FIELD_VALUE_OFS = 7'h0B, TEMPERATURE_VALUE_OFS = 7'h0C, FRONTEND_FLAGS_OFS = 7'h0D,
    SYSTEM_FLAGS_OFS = 7'h0E, TEST_SETUP_OFS = 7'h0F, OSCILLATOR_CHECK_OFS = 7'h10,
    GAIN_CORRECTION_SETUP_OFS = 7'h11, OFFSET_CORRECTION_SETUP_OFS = 7'h12,
    ANGLE_VALUE_OFS = 7'h13, FIELD_MAGNITUDE_VALUE_OFS = 7'h14;
  // One bit per offset: set where software may write
  localparam logic [20:0] WRITABLE_MASK = 21'h0680FF;
  // Slot of each read-only offset within the core word bundle
  localparam int RO_SLOT [REG_COUNT] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2,
                                         3, 4, 5, 6, 0, 7, 0, 0, 8, 9};
  localparam logic [5:0] ADDR_LAST_BIT = 6'h07;
  localparam logic [5:0] FRAME_LEN     = 6'h20;
  localparam logic [5:0] COUNT_MAX     = 6'h3F;
  localparam logic [15:0] DEVCFG_RESET  = 16'h0000;
  localparam logic [15:0] DEVCFG_WMASK  = 16'h737E;
  localparam logic [15:0] AVG_FIELD     = 16'h7000;
  localparam logic [15:0] OP_FIELD      = 16'h0070;
  localparam int AVG_LSB = 12, DRIFT_LSB = 8, OP_LSB = 4;
  localparam int TEMP_ON_BIT = 3, TEMP_RATE_BIT = 2, TEMP_LIMIT_BIT = 1;
  localparam logic [2:0] AVG_MAX_CODE = 3'h5;
  localparam logic [2:0] OP_UNUSED    = 3'h7;
  // Magnet drift in hundredths of a percent per degree C
  localparam logic [4:0] COEF_NONE = 5'h00, COEF_NDFEB = 5'h0C;
  localparam logic [4:0] COEF_SMCO = 5'h03, COEF_CERAMIC = 5'h14;
  typedef enum logic [2:0] {
    OP_CONFIG = 3'h0, OP_STANDBY = 3'h1, OP_MEASURE = 3'h2, OP_TRIGGER = 3'h3,
    OP_WAKE_SLEEP = 3'h4, OP_SLEEP = 3'h5, OP_DEEP_SLEEP = 3'h6
  } op_state_t;
  typedef struct packed {
    logic [2:0] avg_code;
    logic [5:0] samples;
    logic [1:0] drift;
    logic [4:0] coef;
    op_state_t  op;
    logic continuous, trigger_on, duty_cycled, sleeping, deep_sleep;
    logic temp_on, temp_once, temp_limit_on;
  } mode_t;
  localparam mode_t MODE_RESET = '{avg_code: 3'h0, samples: 6'h01, drift: 2'h0,
    coef: 5'h00, op: OP_CONFIG, trigger_on: 1'b1, default: 1'b0};
endpackage : dcfg_pkg

// ==== hdl/dcfg_if.sv ====
// Carrier between the frame shifter, the mode decoder and the bank.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
interface dcfg_if;
  logic              frame_start;
  logic              addr_ready;
  logic [6:0]        addr;
  logic              is_read;
  logic [15:0]       rd_word;
  logic              frame_done;
  logic              frame_ok;
  logic              wr_req;
  logic [6:0]        wr_addr;
  logic [15:0]       wr_data;
  logic [15:0]       cfg_word;
  dcfg_pkg::mode_t   mode;
  modport spi (output frame_start, addr_ready, addr, is_read, frame_done,
               output frame_ok, wr_req, wr_addr, wr_data, input rd_word);
  modport core (input frame_start, addr_ready, addr, is_read, frame_done,
                input frame_ok, wr_req, wr_addr, wr_data, mode,
                output rd_word, cfg_word);
  modport dec (input cfg_word, output mode);
endinterface : dcfg_if

// ==== hdl/spi_frame_shifter.sv ====
// Serial frame engine: pin synchronisers, 32-bit receive and in-frame reply.
// Assumes the bank answers rd_word in the cycle addr_ready is high.
`timescale 1ns/1ps
module spi_frame_shifter (
  input  wire logic clk_in,       // Device clock
  input  wire logic reset_in,     // Synchronous reset, high
  input  wire logic cs_n_in,      // Chip select pin, low active
  input  wire logic sck_in,       // Serial clock pin
  input  wire logic sdi_in,       // Serial data in pin
  output logic      sdo_out,      // Serial data out
  output logic      sdo_oe_n_out, // Low while driving data out
  dcfg_if.spi       bus           // Frame events to the bank
);
  logic [2:0]  cs_sync, sck_sync, sdi_sync;
  logic        cs_f, sck_f;
  logic [5:0]  bit_count;
  logic [31:0] rx_word, tx_word;
  // Select and clock changes taken once the second and third stages agree; data comes from the third stage
  wire next_cs  = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_f;
  wire next_sck = (sck_sync[1] == sck_sync[2]) ? sck_sync[2] : sck_f;
  wire next_sdi = sdi_sync[2];
  wire sck_rise = ~cs_f & ~sck_f & next_sck;
  wire at_addr  = sck_rise & (bit_count == dcfg_pkg::ADDR_LAST_BIT);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cs_sync <= 3'h7;
      sck_sync <= 3'h0;
      sdi_sync <= 3'h0;
      cs_f <= 1'b1;
      sck_f <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n_in};
      sck_sync <= {sck_sync[1:0], sck_in};
      sdi_sync <= {sdi_sync[1:0], sdi_in};
      cs_f <= next_cs;
      sck_f <= next_sck;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in || bus.frame_start) begin
      bit_count <= 6'h00;
      rx_word <= 32'h0000_0000;
      tx_word <= 32'h0000_0000;
    end else if (sck_rise) begin
      rx_word <= {rx_word[30:0], next_sdi};
      bit_count <= (bit_count == dcfg_pkg::COUNT_MAX) ? bit_count : bit_count + 6'h01;
      tx_word <= at_addr ? {bus.rd_word, 16'h0000} : {tx_word[30:0], 1'b0};
    end
  end
  assign sdo_out = tx_word[31];
  assign sdo_oe_n_out = cs_f;
  assign bus.frame_start = cs_f & ~next_cs;
  assign bus.frame_done = ~cs_f & next_cs;
  assign bus.addr_ready = at_addr;
  assign bus.addr = {rx_word[5:0], next_sdi};
  assign bus.is_read = rx_word[6];
  assign bus.frame_ok = (bit_count == dcfg_pkg::FRAME_LEN);
  assign bus.wr_req = ~rx_word[31];
  assign bus.wr_addr = rx_word[30:24];
  assign bus.wr_data = rx_word[23:8];
  a_reply_load : assert property (@(posedge clk_in) disable iff (reset_in)
    at_addr |=> tx_word[31:16] == $past(bus.rd_word))
    else $error("reply word not loaded after address");
endmodule : spi_frame_shifter

// ==== hdl/dcfg_decode.sv ====
// Turns the operation control word into registered mode signals.
// Assumes the word is already cleaned of reserved bits.
`timescale 1ns/1ps
module dcfg_decode (
  input wire logic clk_in,   // Device clock
  input wire logic reset_in, // Synchronous reset, high
  dcfg_if.dec      bus       // Control word in, modes out
);
  dcfg_pkg::mode_t next_mode;
  wire [2:0] avg_raw = bus.cfg_word[dcfg_pkg::AVG_LSB +: 3];
  wire [2:0] op_raw  = bus.cfg_word[dcfg_pkg::OP_LSB +: 3];
  wire [2:0] avg_ok  = (avg_raw > dcfg_pkg::AVG_MAX_CODE) ? 3'h0 : avg_raw;
  always_comb begin
    next_mode = dcfg_pkg::MODE_RESET;
    next_mode.avg_code = avg_ok;
    next_mode.samples = 6'(6'h01 << avg_ok);
    next_mode.drift = bus.cfg_word[dcfg_pkg::DRIFT_LSB +: 2];
    unique case (next_mode.drift)
      2'h0: next_mode.coef = dcfg_pkg::COEF_NONE;
      2'h1: next_mode.coef = dcfg_pkg::COEF_NDFEB;
      2'h2: next_mode.coef = dcfg_pkg::COEF_SMCO;
      2'h3: next_mode.coef = dcfg_pkg::COEF_CERAMIC;
    endcase
    unique case (op_raw)
      dcfg_pkg::OP_STANDBY: next_mode.op = dcfg_pkg::OP_STANDBY;
      dcfg_pkg::OP_MEASURE: next_mode.op = dcfg_pkg::OP_MEASURE;
      dcfg_pkg::OP_TRIGGER: next_mode.op = dcfg_pkg::OP_TRIGGER;
      dcfg_pkg::OP_WAKE_SLEEP: next_mode.op = dcfg_pkg::OP_WAKE_SLEEP;
      dcfg_pkg::OP_SLEEP: next_mode.op = dcfg_pkg::OP_SLEEP;
      dcfg_pkg::OP_DEEP_SLEEP: next_mode.op = dcfg_pkg::OP_DEEP_SLEEP;
      default: next_mode.op = dcfg_pkg::OP_CONFIG;
    endcase
    next_mode.continuous = (next_mode.op == dcfg_pkg::OP_MEASURE);
    next_mode.trigger_on = (next_mode.op == dcfg_pkg::OP_CONFIG) ||
                           (next_mode.op == dcfg_pkg::OP_STANDBY) ||
                           (next_mode.op == dcfg_pkg::OP_TRIGGER);
    next_mode.duty_cycled = (next_mode.op == dcfg_pkg::OP_WAKE_SLEEP);
    next_mode.sleeping = (next_mode.op == dcfg_pkg::OP_SLEEP);
    next_mode.deep_sleep = (next_mode.op == dcfg_pkg::OP_DEEP_SLEEP);
    next_mode.temp_on = bus.cfg_word[dcfg_pkg::TEMP_ON_BIT];
    next_mode.temp_once = bus.cfg_word[dcfg_pkg::TEMP_RATE_BIT];
    next_mode.temp_limit_on = bus.cfg_word[dcfg_pkg::TEMP_LIMIT_BIT];
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bus.mode <= dcfg_pkg::MODE_RESET;
    end else begin
      bus.mode <= next_mode;
    end
  end
endmodule : dcfg_decode

// ==== hdl/sensor_register_map_devcfg.sv ====
// Register bank of a three-axis field sensor, reached over 32-bit frames.
// Assumes the conversion core supplies the read-only words and consumes
// the setup words and decoded operating modes.
`timescale 1ns/1ps
// What this block does
// - Operation control register resets to all zero.
// - Averaging codes 0h to 5h select 1x to 32x sampling.
// - Averaging codes 6h and 7h act as code 0h.
// - Drift field selects none, 0.12, 0.03 or 0.2 %/deg C compensation.
// - Operating state codes select configuration, standby, trigger, duty-cycled, sleep.
// - State code 2h converts continuously without trigger.
// - Deep sleep state 6h is left when chip select is asserted.
// - State code 7h falls back to configuration.
// - Bit 3 includes the temperature channel in conversions.
// - Bit 2 converts temperature once per set instead of averaged.
// - Bit 1 turns the temperature limit check on.
// - A read frame returns the addressed word within the same frame.
module sensor_register_map_devcfg (
  input  wire logic          clk_in,                  // Device clock, 125 MHz
  input  wire logic          reset_in,                // Synchronous reset, high
  input  wire logic          cs_n_in,                 // Chip select pin, low active
  input  wire logic          sck_in,                  // Serial clock pin
  input  wire logic          sdi_in,                  // Serial data in pin
  output logic               sdo_out,                 // Serial data out
  output logic               sdo_oe_n_out,            // Low while data out is driven
  input  wire logic [159:0]  core_words_in,           // Read-only words, slot order
  output logic      [335:0]  setup_words_out,         // Stored words by offset
  output logic      [2:0]    averaging_factor_out,    // Effective averaging code
  output logic      [5:0]    averaging_samples_out,   // Samples per result
  output logic      [1:0]    magnet_drift_comp_out,   // Drift compensation code
  output logic      [4:0]    drift_coef_out,          // Drift in 0.01 %/deg C
  output logic      [2:0]    operating_state_out,     // Effective operating state
  output logic               convert_continuous_out,  // Free-running conversions
  output logic               trigger_enabled_out,     // Trigger input honoured
  output logic               duty_cycled_out,         // Wake-up and sleep cycling
  output logic               sleep_out,               // Sleep state
  output logic               deep_sleep_out,          // Deep sleep state
  output logic               temp_channel_on_out,     // Temperature acquired
  output logic               temp_once_per_set_out,   // Temperature once per set
  output logic               temp_limit_check_on_out  // Temperature limit check
);
  dcfg_if link ();

  spi_frame_shifter u_shifter (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .cs_n_in      (cs_n_in),
    .sck_in       (sck_in),
    .sdi_in       (sdi_in),
    .sdo_out      (sdo_out),
    .sdo_oe_n_out (sdo_oe_n_out),
    .bus          (link)
  );

  dcfg_decode u_decode (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .bus      (link)
  );

  logic [15:0] mem  [dcfg_pkg::REG_COUNT];
  logic [15:0] view [dcfg_pkg::REG_COUNT];
  logic [15:0] next_devcfg;

  wire [15:0] devcfg = mem[0];
  wire [2:0]  devcfg_op = devcfg[dcfg_pkg::OP_LSB +: 3];

  // Read-only offsets show the core, writable ones their stored word
  genvar gi;
  generate
    for (gi = 0; gi < dcfg_pkg::REG_COUNT; gi = gi + 1) begin : g_map
      if (dcfg_pkg::WRITABLE_MASK[gi]) begin : g_rw
        assign view[gi] = mem[gi];
      end else begin : g_ro
        assign view[gi] = core_words_in[dcfg_pkg::RO_SLOT[gi] * 16 +: 16];
      end
      assign setup_words_out[gi * 16 +: 16] = mem[gi];
    end
  endgenerate

  // Read side: word is captured as the eighth frame bit arrives
  wire        rd_mapped = (link.addr <= dcfg_pkg::LAST_OFS);
  wire [15:0] rd_pick   = rd_mapped ? view[link.addr[4:0]] : 16'h0000;
  assign link.rd_word = link.is_read ? rd_pick : 16'h0000;

  // Write side: only whole 32-bit frames to writable offsets take effect
  wire wr_mapped = (link.wr_addr <= dcfg_pkg::LAST_OFS);
  wire wr_take   = link.frame_done & link.frame_ok & link.wr_req & wr_mapped &
                   dcfg_pkg::WRITABLE_MASK[link.wr_addr[4:0]];
  wire wr_devcfg = wr_take & (link.wr_addr == dcfg_pkg::DEVICE_OPERATION_CONTROL_OFS);
  wire wr_other  = wr_take & ~wr_devcfg;

  wire [15:0] wr_masked = link.wr_data & dcfg_pkg::DEVCFG_WMASK;
  wire        avg_bad   = wr_masked[dcfg_pkg::AVG_LSB +: 3] > dcfg_pkg::AVG_MAX_CODE;
  wire        op_bad    = wr_masked[dcfg_pkg::OP_LSB +: 3] == dcfg_pkg::OP_UNUSED;
  wire [15:0] avg_clear = avg_bad ? dcfg_pkg::AVG_FIELD : 16'h0000;
  wire [15:0] op_clear  = op_bad ? dcfg_pkg::OP_FIELD : 16'h0000;
  // Unused codes are stored as zero so reads agree with behaviour
  wire [15:0] wr_clean  = wr_masked & ~avg_clear & ~op_clear;

  // Chip select assertion ends deep sleep; state returns to configuration
  wire deep_wake = link.frame_start & (devcfg_op == dcfg_pkg::OP_DEEP_SLEEP);

  always_comb begin
    next_devcfg = devcfg;
    if (wr_devcfg) begin
      next_devcfg = wr_clean;
    end else if (deep_wake) begin
      next_devcfg = devcfg & ~dcfg_pkg::OP_FIELD;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 1; i < dcfg_pkg::REG_COUNT; i++) begin
        mem[i] <= 16'h0000;
      end
      mem[0] <= dcfg_pkg::DEVCFG_RESET;
    end else begin
      mem[0] <= next_devcfg;
      if (wr_other) begin
        mem[link.wr_addr[4:0]] <= link.wr_data;
      end
    end
  end

  assign link.cfg_word = devcfg;

  // Decoded modes leave the decoder flops one cycle after the word
  assign averaging_factor_out    = link.mode.avg_code;
  assign averaging_samples_out   = link.mode.samples;
  assign magnet_drift_comp_out   = link.mode.drift;
  assign drift_coef_out          = link.mode.coef;
  assign operating_state_out     = link.mode.op;
  assign convert_continuous_out  = link.mode.continuous;
  assign trigger_enabled_out     = link.mode.trigger_on;
  assign duty_cycled_out         = link.mode.duty_cycled;
  assign sleep_out               = link.mode.sleeping;
  assign deep_sleep_out          = link.mode.deep_sleep;
  assign temp_channel_on_out     = link.mode.temp_on;
  assign temp_once_per_set_out   = link.mode.temp_once;
  assign temp_limit_check_on_out = link.mode.temp_limit_on;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  wire [2:0] wr_avg = link.wr_data[dcfg_pkg::AVG_LSB +: 3];
  wire [2:0] wr_op  = link.wr_data[dcfg_pkg::OP_LSB +: 3];
  // Stored averaging code; a fixed table below checks each count
  wire [2:0] avg_now = devcfg[dcfg_pkg::AVG_LSB +: 3];

  property p_reset_clear;
    @(posedge clk_in) disable iff (1'b0)
    reset_in |=> (devcfg == 16'h0000) ##1 (operating_state_out == 3'h0);
  endproperty
  a_reset_clear : assert property (p_reset_clear)
    else $error("control register not zero after reset");

  a_avg_samples : assert property (
    ##1 averaging_samples_out == 6'(6'h01 << $past(devcfg[dcfg_pkg::AVG_LSB +: 3]))
      || $past(devcfg[dcfg_pkg::AVG_LSB +: 3]) > 3'h5)
    else $error("sample count does not follow averaging code");

  a_avg_unused : assert property (
    wr_devcfg && wr_avg > 3'h5 |=> devcfg[dcfg_pkg::AVG_LSB +: 3] == 3'h0
      ##1 averaging_samples_out == 6'h01)
    else $error("unused averaging code not treated as zero");

  sequence s_drift_code(logic [1:0] code);
    devcfg[dcfg_pkg::DRIFT_LSB +: 2] == code;
  endsequence
  a_drift_ndfeb : assert property (
    s_drift_code(2'h1) |=> drift_coef_out == 5'h0C && magnet_drift_comp_out == 2'h1)
    else $error("drift coefficient wrong for code 1");
  a_drift_ceramic : assert property (
    s_drift_code(2'h3) |=> drift_coef_out == 5'h14)
    else $error("drift coefficient wrong for code 3");

  a_state_sleepy : assert property (
    devcfg_op == 3'h4 |=> duty_cycled_out && !sleep_out && !trigger_enabled_out)
    else $error("wake-up and sleep state not decoded");
  a_state_trigger : assert property (
    devcfg_op == 3'h1 || devcfg_op == 3'h3 |=> trigger_enabled_out && !convert_continuous_out)
    else $error("trigger states not decoded");

  a_continuous_run : assert property (
    devcfg_op == 3'h2 [*2] |=> convert_continuous_out && !trigger_enabled_out)
    else $error("continuous conversion not selected");

  a_deep_wake : assert property (
    deep_wake |=> devcfg_op == 3'h0 ##1 !deep_sleep_out && operating_state_out == 3'h0)
    else $error("deep sleep not left at chip select");

  a_op_unused : assert property (
    wr_devcfg && wr_op == 3'h7 |=> devcfg_op == 3'h0 ##1 trigger_enabled_out)
    else $error("unused state code not treated as configuration");

  a_temp_bits : assert property (
    $changed(devcfg[3:1]) |=> {temp_channel_on_out, temp_once_per_set_out,
                                temp_limit_check_on_out} == $past(devcfg[3:1]))
    else $error("temperature controls do not follow bits 3 to 1");
  a_temp_rate : assert property (
    devcfg[dcfg_pkg::TEMP_RATE_BIT] |=> temp_once_per_set_out)
    else $error("temperature rate bit not applied");
  a_temp_limit : assert property (
    !devcfg[dcfg_pkg::TEMP_LIMIT_BIT] |=> !temp_limit_check_on_out)
    else $error("temperature limit check on while bit clear");

  a_reserved_zero : assert property (
    (devcfg & ~dcfg_pkg::DEVCFG_WMASK) == 16'h0000)
    else $error("reserved control bits set");

  a_read_word : assert property (
    link.addr_ready && link.is_read && rd_mapped |-> link.rd_word == view[link.addr[4:0]])
    else $error("read frame does not return addressed word");
  a_write_zero : assert property (
    link.addr_ready && !link.is_read |-> link.rd_word == 16'h0000)
    else $error("write frame reply not zero");
  a_unmapped_hold : assert property (
    link.frame_done && link.wr_req && !wr_take |=> $stable(setup_words_out))
    else $error("refused write changed state");

  property p_avg_1x;
    avg_now == 3'h0 |=> averaging_samples_out == 6'h01;
  endproperty
  a_avg_one : assert property (p_avg_1x)
    else $error("code 0 not one sample");

  property p_avg_2x;
    avg_now == 3'h1 |=> averaging_samples_out == 6'h02;
  endproperty
  a_avg_two : assert property (p_avg_2x)
    else $error("code 1 not two samples");

  property p_avg_4x;
    avg_now == 3'h2 |=> averaging_samples_out == 6'h04;
  endproperty
  a_avg_four : assert property (p_avg_4x)
    else $error("code 2 not four samples");

  property p_avg_8x;
    avg_now == 3'h3 |=> averaging_samples_out == 6'h08;
  endproperty
  a_avg_eight : assert property (p_avg_8x)
    else $error("code 3 not eight samples");

  property p_avg_16x;
    avg_now == 3'h4 |=> averaging_samples_out == 6'h10;
  endproperty
  a_avg_sixteen : assert property (p_avg_16x)
    else $error("code 4 not sixteen samples");

  property p_avg_32x;
    avg_now == 3'h5 |=> averaging_samples_out == 6'h20;
  endproperty
  a_avg_thirtytwo : assert property (p_avg_32x)
    else $error("code 5 not thirty-two samples");

  property p_avg_stored;
    avg_now <= dcfg_pkg::AVG_MAX_CODE;
  endproperty
  a_avg_range : assert property (p_avg_stored)
    else $error("unused averaging code stored");

  property p_drift_none;
    s_drift_code(2'h0) |=> drift_coef_out == 5'h00;
  endproperty
  a_drift_none : assert property (p_drift_none)
    else $error("drift coefficient wrong for code 0");

  property p_drift_low;
    s_drift_code(2'h2) |=> drift_coef_out == 5'h03 && magnet_drift_comp_out == 2'h2;
  endproperty
  a_drift_low : assert property (p_drift_low)
    else $error("drift coefficient wrong for code 2");

  property p_state_config;
    devcfg_op == 3'h0 |=> trigger_enabled_out && operating_state_out == 3'h0;
  endproperty
  a_state_config : assert property (p_state_config)
    else $error("configuration state not decoded");

  property p_state_standby;
    devcfg_op == 3'h1 |=> operating_state_out == 3'h1 && !sleep_out;
  endproperty
  a_state_standby : assert property (p_state_standby)
    else $error("standby state not decoded");

  property p_state_sleep;
    devcfg_op == 3'h5 |=> sleep_out && !duty_cycled_out && !trigger_enabled_out;
  endproperty
  a_state_sleep : assert property (p_state_sleep)
    else $error("sleep state not decoded");

  property p_deep_flag;
    devcfg_op == 3'h6 |=> deep_sleep_out && operating_state_out == 3'h6;
  endproperty
  a_deep_flag : assert property (p_deep_flag)
    else $error("deep sleep state not decoded");

  property p_temp_on;
    devcfg[dcfg_pkg::TEMP_ON_BIT] |=> temp_channel_on_out;
  endproperty
  a_temp_on : assert property (p_temp_on)
    else $error("temperature channel not included");

  property p_temp_off;
    !devcfg[dcfg_pkg::TEMP_ON_BIT] |=> !temp_channel_on_out;
  endproperty
  a_temp_off : assert property (p_temp_off)
    else $error("temperature channel not excluded");

  property p_temp_averaged;
    !devcfg[dcfg_pkg::TEMP_RATE_BIT] |=> !temp_once_per_set_out;
  endproperty
  a_temp_averaged : assert property (p_temp_averaged)
    else $error("temperature not averaged while bit clear");

  property p_limit_on;
    devcfg[dcfg_pkg::TEMP_LIMIT_BIT] |=> temp_limit_check_on_out;
  endproperty
  a_limit_on : assert property (p_limit_on)
    else $error("temperature limit check off while bit set");

  property p_reset_words;
    @(posedge clk_in) disable iff (1'b0)
    reset_in |=> setup_words_out == 336'h0 && sdo_oe_n_out;
  endproperty
  a_reset_words : assert property (p_reset_words)
    else $error("stored words or enable not idle after reset");

  property p_oe_frame;
    link.frame_start |=> !sdo_oe_n_out;
  endproperty
  a_oe_frame : assert property (p_oe_frame)
    else $error("data out not enabled in frame");

  c_read_frame : cover property (link.addr_ready && link.is_read ##[1:600] link.frame_done);
  c_devcfg_write : cover property (wr_devcfg && wr_op == 3'h2);
  c_deep_wake : cover property (deep_wake);
  c_other_write : cover property (wr_other);
  c_short_frame : cover property (link.frame_done && !link.frame_ok);
endmodule : sensor_register_map_devcfg

// ==== verif/spi_ctrl_model.sv ====
// Serial controller model: drives 32-bit frames and captures the reply.
// Assumes the bench calls xfer with the device clock running.
`timescale 1ns/1ps
module spi_ctrl_model (
  input  wire logic clk_in,      // Device clock
  input  wire logic sdo_in,      // Reply line from device
  output logic      cs_n_out,    // Chip select, low active
  output logic      sck_out,     // Serial clock, idle low
  output logic      sdi_out      // Serial data to device
);
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    sdi_out  = 1'b0;
  end
  // Five clocks per phase keeps clear of the 4-clock minimum
  task automatic xfer(input logic [31:0] f, input int n, output logic [31:0] rx);
    rx = '0;
    cs_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      sdi_out <= f[31-i];
      repeat (5) @(posedge clk_in);
      rx = {rx[30:0], sdo_in};
      sck_out <= 1'b1;
      repeat (5) @(posedge clk_in);
      sck_out <= 1'b0;
    end
    repeat (5) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // Released line must not keep showing the last bit
    sdi_out <= ~sdi_out;
    repeat (6) @(posedge clk_in);
  endtask : xfer
endmodule : spi_ctrl_model

// ==== verif/sensor_register_map_devcfg_tb_top.sv ====
// Self-checking bench for the sensor register bank.
// Assumes only the serial pins and the core word bundle reach the bank.
`timescale 1ns/1ps
module sensor_register_map_devcfg_tb_top;
  logic         clk_in = 1'b0;
  logic         reset_in = 1'b1;
  logic [159:0] core_words = '0;
  logic [335:0] setup_words;
  logic [2:0]   avg, state;
  logic [5:0]   samples;
  logic [1:0]   drift;
  logic [4:0]   coef;
  logic         sdo, sdo_oe_n, cont, trig, duty, slp, dslp, ton, tonce, tlim;
  wire          cs_n, sck, sdi;
  int           n_fail = 0, n_tests = 0, cycles = 0;
  logic [15:0]  d;
  always #4 clk_in = ~clk_in;
  spi_ctrl_model ctrl (.clk_in(clk_in), .sdo_in(sdo), .cs_n_out(cs_n), .sck_out(sck),
    .sdi_out(sdi));
  sensor_register_map_devcfg dut (.clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n),
    .sck_in(sck), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
    .core_words_in(core_words), .setup_words_out(setup_words),
    .averaging_factor_out(avg), .averaging_samples_out(samples),
    .magnet_drift_comp_out(drift), .drift_coef_out(coef), .operating_state_out(state),
    .convert_continuous_out(cont), .trigger_enabled_out(trig), .duty_cycled_out(duty),
    .sleep_out(slp), .deep_sleep_out(dslp), .temp_channel_on_out(ton),
    .temp_once_per_set_out(tonce), .temp_limit_check_on_out(tlim));
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic wr(input logic [6:0] ofs, input logic [15:0] v);
    logic [31:0] rx;
    ctrl.xfer({1'b0, ofs, v, 8'h00}, 32, rx);
    chk(rx, 32'h0);
    repeat (6) @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [6:0] ofs, output logic [15:0] v);
    logic [31:0] rx;
    ctrl.xfer({1'b1, ofs, 24'h0}, 32, rx);
    chk({rx[31:24], rx[7:0]}, 32'h0);
    v = rx[23:8];
    repeat (6) @(posedge clk_in);
  endtask : rd
  task automatic t_reset();
    chk({sdo_oe_n, sdo}, 32'h2);
    fork
      rd(7'h00, d);
      begin
        repeat (20) @(posedge clk_in);
        chk(sdo_oe_n, 32'h0);
      end
    join
    chk(d, 32'h0);
    chk({trig, samples, avg, state, cont, duty, slp, dslp}, {1'b1, 6'h01, 10'h0});
  endtask : t_reset
  task automatic t_avg();
    logic [2:0] e;
    for (int c = 0; c < 8; c++) begin
      wr(7'h00, 16'(c) << 12);
      e = (c > 5) ? 3'h0 : 3'(c);
      chk({avg, samples}, {e, 6'(1 << e)});
      rd(7'h00, d);
      chk(d, {1'b0, e, 12'h000});
    end
  endtask : t_avg
  task automatic t_drift();
    logic [4:0] tbl [4] = '{5'h00, 5'h0C, 5'h03, 5'h14};
    for (int c = 0; c < 4; c++) begin
      wr(7'h00, 16'(c) << 8);
      chk({drift, coef}, {2'(c), tbl[c]});
    end
  endtask : t_drift
  task automatic t_state();
    logic [2:0] e;
    for (int s = 0; s < 8; s++) begin
      if (s != 6) begin
        wr(7'h00, 16'(s) << 4);
        e = (s == 7) ? 3'h0 : 3'(s);
        chk(state, e);
        chk({cont, trig, duty, slp, dslp}, {e == 2, e < 2 || e == 3, e == 4, e == 5, 1'b0});
      end
    end
  endtask : t_state
  task automatic t_deep();
    wr(7'h00, 16'h0060);
    chk({dslp, state}, {1'b1, 3'h6});
    rd(7'h00, d);
    chk({dslp, state, d}, 20'h0);
  endtask : t_deep
  task automatic t_temp();
    wr(7'h00, 16'hFFFF);
    chk({ton, tonce, tlim}, 3'b111);
    rd(7'h00, d);
    chk(d, 16'h030E);
    wr(7'h00, 16'h000A);
    chk({ton, tonce, tlim}, 3'b101);
  endtask : t_temp
  task automatic t_map();
    logic [31:0] rx;
    wr(7'h01, 16'hA5C3);
    rd(7'h01, d);
    chk({d, setup_words[16 +: 16]}, 32'hA5C3A5C3);
    ctrl.xfer({1'b0, 7'h01, 16'h1111, 8'h00}, 31, rx);
    repeat (6) @(posedge clk_in);
    rd(7'h01, d);
    chk(d, 16'hA5C3);
    @(posedge clk_in);
    core_words[144 +: 16] <= 16'h5A3C;
    rd(7'h14, d);
    chk(d, 16'h5A3C);
    rd(7'h15, d);
    chk(d, 16'h0000);
    core_words[0 +: 16] <= 16'hC35A;
    wr(7'h08, 16'h1111);
    rd(7'h08, d);
    chk({d, setup_words[128 +: 16]}, 32'hC35A0000);
  endtask : t_map
  // Forty-one frames of about 340 clocks each fit well under this ceiling
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_avg();
    t_drift();
    t_state();
    t_deep();
    t_temp();
    t_map();
    wrap_up();
  end
endmodule : sensor_register_map_devcfg_tb_top
